/* inc/i2c_wr_port_map.vh */
// Purpose: Register offsets, reset values and slave byte addresses.
// Assumes: Included by the write port design file and by the bench.
// Notes: Offsets are internal register bus byte addresses.
`ifndef I2C_WR_PORT_MAP_VH
`define I2C_WR_PORT_MAP_VH
`define WRITE_ADDRESS_FIELD_REG_OFFSET 24'h01d200
`define WDATA_REG_OFFSET 24'h01d204
`define WRITE_ADDRESS_FIELD_RESET 32'h00000000
`define WDATA_RESET 32'h00000000
`define SLV_ADDR_B0 8'h00
`define SLV_DATA_LSB 8'h04
`define SLV_DATA_MSB 8'h07
`define SLV_AFTER_MSB 8'h08
`define ADDR_STEP 32'h00000004
`define ADDR_ALIGN_MASK 32'hfffffffc
`define SIZE_4BYTE 2'h3
`endif

/* rtl/link_sync.v */
// Purpose: Two flop synchroniser for one level from outside the clock.
// Assumes: Input is asynchronous to ref_clk_i.
// Notes: The first flop feeds only the second.
`timescale 1ns/100ps
module link_sync (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire async_i,
  output reg sync_o
);
  reg meta_q;
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // link_sync

/* rtl/i2c_wr_port.v */
// Purpose: Write half of the slave window onto the internal register bus.
// Assumes: Byte events arrive as one-cycle strobes from the slave engine
//          on ref_clk_i; control settings are static or on this clock.
// Notes: The start bit of a transfer is a link level and is synchronised.
//        The start pointer rides with it and has its own two flops.
`timescale 1ns/100ps
`include "i2c_wr_port_map.vh"
module i2c_wr_port (
  // Clock and reset.
  input wire ref_clk_i,
  input wire reset_n_i,
  // Slave engine byte events.
  input wire xfer_start_i,
  input wire [7:0] start_ptr_i,
  input wire byte_wr_i,
  input wire byte_rd_i,
  input wire [7:0] byte_data_i,
  // Access control settings.
  input wire write_auto_increment_enable_i,
  input wire [1:0] write_access_size_i,
  // Boot load deposits.
  input wire boot_addr_load_i,
  input wire boot_data_load_i,
  input wire [31:0] boot_word_i,
  // Register bus read port.
  input wire reg_rd_i,
  input wire [23:0] reg_rd_addr_i,
  output reg [31:0] reg_rd_data_o,
  output reg reg_rd_hit_o,
  // Slave byte readback.
  output reg [7:0] slave_rd_data_o,
  output reg [7:0] byte_ptr_o,
  // Internal register write master.
  output reg int_wr_o,
  output reg [23:0] int_wr_addr_o,
  output reg [31:0] int_wr_data_o,
  output reg [3:0] int_wr_lanes_o
);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Lane n is bits 8n+7 down to 8n, so pointer 0x04 holds the least
  // significant data byte and pointer 0x07 the most significant one.
  function [31:0] put_byte;
    input [31:0] word;
    input [1:0] lane;
    input [7:0] val;
    begin
      put_byte = word;
      put_byte[lane*8 +: 8] = val;
    end
  endfunction

  function [7:0] get_byte;
    input [31:0] word;
    input [1:0] lane;
    begin
      get_byte = word[lane*8 +: 8];
    end
  endfunction

  // --------------------------------------------------------------
  // Start synchroniser and edge detect
  // --------------------------------------------------------------
  wire start_sync;
  reg start_prev_q;
  link_sync u_start_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(xfer_start_i),
    .sync_o(start_sync)
  );
  wire start_evt = start_sync & ~start_prev_q;

  // --------------------------------------------------------------
  // Start pointer capture
  // --------------------------------------------------------------
  // The pointer comes from outside this clock together with the start
  // level, so it passes two flops as well. Bits may land a cycle apart,
  // but the pointer is held long before the start edge leaves its own
  // synchroniser, so only the settled value is ever loaded.
  reg [7:0] ptr_meta_q;
  reg [7:0] ptr_sync_q;
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ptr_meta_q <= `SLV_ADDR_B0;
      ptr_sync_q <= `SLV_ADDR_B0;
    end else begin
      ptr_meta_q <= start_ptr_i;
      ptr_sync_q <= ptr_meta_q;
    end
  end

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  reg [31:0] ext_internal_write_address_reg;
  reg [31:0] ext_internal_write_data_reg;
  reg [7:0] ptr_q;
  // Window bases are compared on the upper six pointer bits only.
  wire [7:0] addr_base = `SLV_ADDR_B0;
  wire [7:0] data_base = `SLV_DATA_LSB;
  wire in_addr = (ptr_q[7:2] == addr_base[7:2]);
  wire in_data = (ptr_q[7:2] == data_base[7:2]);
  wire msb_hit = (ptr_q == `SLV_DATA_MSB);
  wire size4 = (write_access_size_i == `SIZE_4BYTE);
  wire [31:0] data_next = put_byte(ext_internal_write_data_reg, ptr_q[1:0],
    byte_data_i);
  // Lanes count from 0x04 up; 0x07 is the top lane of the word.
  wire [3:0] lane_sel = 4'h1 << ptr_q[1:0];

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ext_internal_write_address_reg <= `WRITE_ADDRESS_FIELD_RESET;
      ext_internal_write_data_reg <= `WDATA_RESET;
      ptr_q <= `SLV_ADDR_B0;
      start_prev_q <= 1'b0;
      int_wr_o <= 1'b0;
      int_wr_addr_o <= 24'h000000;
      int_wr_data_o <= 32'h00000000;
      int_wr_lanes_o <= 4'h0;
    end else begin
      start_prev_q <= start_sync;
      int_wr_o <= 1'b0;
      // Boot deposits are assigned first, so a slave write to the same
      // register in the same cycle, assigned below, takes precedence.
      if (boot_addr_load_i) begin
        ext_internal_write_address_reg <= boot_word_i & `ADDR_ALIGN_MASK;
      end
      if (boot_data_load_i) begin
        ext_internal_write_data_reg <= boot_word_i;
      end
      if (start_evt) begin
        ptr_q <= ptr_sync_q;
      end else if (byte_wr_i) begin
        if (in_addr) begin
          // Low lane bits are forced clear to keep word alignment.
          ext_internal_write_address_reg <= put_byte(
            ext_internal_write_address_reg, ptr_q[1:0], byte_data_i)
            & `ADDR_ALIGN_MASK;
        end
        if (in_data) begin
          ext_internal_write_data_reg <= data_next;
        end
        if (msb_hit) begin
          // The wrap lets a master stream words without sending a new
          // start pointer for each one.
          ptr_q <= `SLV_DATA_LSB;
          if (size4) begin
            int_wr_o <= 1'b1;
            int_wr_addr_o <= ext_internal_write_address_reg[23:0];
            int_wr_data_o <= data_next;
            int_wr_lanes_o <= 4'hf;
          end else begin
            // Narrow sizes are not decoded here, so no access is made.
            int_wr_lanes_o <= lane_sel;
          end
          if (write_auto_increment_enable_i) begin
            ext_internal_write_address_reg <=
              ext_internal_write_address_reg + `ADDR_STEP;
          end
        end else begin
          ptr_q <= ptr_q + 8'h01;
        end
      end else if (byte_rd_i) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------
  // Read paths
  // --------------------------------------------------------------
  // Register bus reads answer one cycle later and return zero on a
  // miss, so a reader that ignores the hit flag still sees no stale
  // value from an earlier access.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      reg_rd_data_o <= 32'h00000000;
      reg_rd_hit_o <= 1'b0;
      slave_rd_data_o <= 8'h00;
      byte_ptr_o <= `SLV_ADDR_B0;
    end else begin
      byte_ptr_o <= ptr_q;
      reg_rd_hit_o <= 1'b0;
      reg_rd_data_o <= 32'h00000000;
      if (reg_rd_i) begin
        if (reg_rd_addr_i == `WRITE_ADDRESS_FIELD_REG_OFFSET) begin
          reg_rd_data_o <= ext_internal_write_address_reg;
          reg_rd_hit_o <= 1'b1;
        end else if (reg_rd_addr_i == `WDATA_REG_OFFSET) begin
          reg_rd_data_o <= ext_internal_write_data_reg;
          reg_rd_hit_o <= 1'b1;
        end
      end
      if (in_addr) begin
        slave_rd_data_o <= get_byte(ext_internal_write_address_reg,
          ptr_q[1:0]);
      end else if (in_data) begin
        slave_rd_data_o <= get_byte(ext_internal_write_data_reg,
          ptr_q[1:0]);
      end else begin
        slave_rd_data_o <= 8'h00;
      end
    end
  end
endmodule // i2c_wr_port

/* test/i2c_master_model.sv */
// Purpose: Outside bus master that issues slave byte events.
// Assumes: Strobes move on the falling clock edge.
// Notes: The start level moves on an 80 ns link tick.
`timescale 1ns/100ps
module i2c_master_model (
  input wire ref_clk_i,
  output logic xfer_start_o = 1'b0,
  output logic [7:0] start_ptr_o = 8'h00,
  output logic byte_wr_o = 1'b0,
  output logic byte_rd_o = 1'b0,
  output logic [7:0] byte_data_o = 8'h00
);
  // The pointer holds all frame long so the slow sync catches it.
  task automatic start(input logic [7:0] p);
    xfer_start_o = 1'b0;
    #80 start_ptr_o = p;
    #80 xfer_start_o = 1'b1;
    #160;
  endtask
  task automatic op(input logic w, input logic [7:0] b);
    @(negedge ref_clk_i);
    byte_wr_o = w;
    byte_rd_o = !w;
    byte_data_o = b;
    @(negedge ref_clk_i);
    {byte_wr_o, byte_rd_o} = 2'b00;
    byte_data_o = ~b;
    repeat (3) @(negedge ref_clk_i);
  endtask
endmodule // i2c_master_model

/* test/i2c_wr_port_chk.sv */
// Purpose: Port checks for the write port.
// Assumes: Byte events come with four idle cycles between.
// Notes: Bound to the design below.
`timescale 1ns/100ps
module i2c_wr_port_chk (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire byte_wr_i,
  input wire byte_rd_i,
  input wire [1:0] write_access_size_i,
  input wire reg_rd_i,
  input wire [23:0] reg_rd_addr_i,
  input wire [31:0] reg_rd_data_o,
  input wire reg_rd_hit_o,
  input wire [7:0] byte_ptr_o,
  input wire int_wr_o,
  input wire [23:0] int_wr_addr_o,
  input wire [3:0] int_wr_lanes_o
);
  // The pointer output lags, so it is trusted after a quiet spell.
  logic [1:0] quiet_q;
  always @(posedge ref_clk_i)
    quiet_q <= reset_n_i ? {quiet_q[0], !(byte_wr_i | byte_rd_i)} : 2'b00;
  wire ok = &quiet_q;
  wire wr7 = byte_wr_i && ok && byte_ptr_o == 8'h07;
  wire wr_low = byte_wr_i && ok && byte_ptr_o >= 8'h04 &&
    byte_ptr_o <= 8'h06;
  wire rd7 = byte_rd_i && ok && byte_ptr_o == 8'h07;
  wire rd_addr = reg_rd_i && reg_rd_addr_i == 24'h01d200;
  wire rd_none = reg_rd_i && reg_rd_addr_i == 24'h01d208;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_msb_launch: assert property (wr7 && write_access_size_i == 2'h3
    |=> int_wr_o) else $error("no launch");
  a_low_quiet: assert property (wr_low |=> !int_wr_o)
    else $error("bad launch");
  a_ptr_wrap: assert property (wr7 |-> ##[1:3] byte_ptr_o == 8'h04)
    else $error("no wrap");
  a_rd_advance: assert property (rd7 |-> ##[1:3]
    byte_ptr_o == 8'h08) else $error("no advance");
  a_word_lanes: assert property (int_wr_o |->
    int_wr_lanes_o == 4'hf && int_wr_addr_o[1:0] == 2'b00)
    else $error("bad lanes");
  a_write_cause: assert property (int_wr_o |-> $past(byte_wr_i))
    else $error("stray write");
  a_addr_hit: assert property (rd_addr |=> reg_rd_hit_o
    && reg_rd_data_o[1:0] == 2'b00) else $error("hit");
  a_reg_miss: assert property (rd_none |=> !reg_rd_hit_o
    && reg_rd_data_o == 32'h0) else $error("miss");
  c_launch: cover property (int_wr_o);
  c_wrap: cover property (wr7);
  c_hit: cover property (reg_rd_hit_o);
endmodule // i2c_wr_port_chk
bind i2c_wr_port i2c_wr_port_chk i2c_wr_port_chk_inst (.ref_clk_i,
  .reset_n_i, .byte_wr_i, .byte_rd_i, .write_access_size_i, .reg_rd_i,
  .reg_rd_addr_i, .reg_rd_data_o, .reg_rd_hit_o, .byte_ptr_o, .int_wr_o,
  .int_wr_addr_o, .int_wr_lanes_o);

/* test/tb.sv */
// Purpose: Self-checking bench for the write port.
// Assumes: The master model spaces its byte events.
// Notes: A queue holds the internal writes the model predicts.
`timescale 1ns/100ps
`include "i2c_wr_port_map.vh"
module tb;
  logic clk = 0, rst_n = 0, inc = 1, rd = 0, bal = 0, bdl = 0;
  logic xs, bwr, brd, hit, iw;
  logic [1:0] size = 2'h3;
  logic [31:0] bw = 0, addr = 0, data = 0, rdata, iwd;
  logic [23:0] ra = 0, iwa;
  logic [7:0] sp, bd, ptr, srd;
  logic [3:0] iwl;
  logic [59:0] exp_q[$];
  logic [59:0] want_wr;
  int p = 0, n_mismatch = 0, checked = 0, cyc = 0;
  integer seed = 85501;
  i2c_wr_port i2c_wr_port_inst (.ref_clk_i(clk), .reset_n_i(rst_n),
    .xfer_start_i(xs), .start_ptr_i(sp), .byte_wr_i(bwr), .byte_rd_i(brd),
    .byte_data_i(bd), .write_auto_increment_enable_i(inc),
    .write_access_size_i(size), .boot_addr_load_i(bal),
    .boot_data_load_i(bdl), .boot_word_i(bw), .reg_rd_i(rd),
    .reg_rd_addr_i(ra), .reg_rd_data_o(rdata), .reg_rd_hit_o(hit),
    .slave_rd_data_o(srd), .byte_ptr_o(ptr), .int_wr_o(iw),
    .int_wr_addr_o(iwa), .int_wr_data_o(iwd), .int_wr_lanes_o(iwl));
  i2c_master_model i2c_master_model_inst (.ref_clk_i(clk),
    .xfer_start_o(xs), .start_ptr_o(sp), .byte_wr_o(bwr),
    .byte_rd_o(brd), .byte_data_o(bd));
  task automatic cmp_reg(input logic [32:0] got, input logic [32:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD %0t register read got %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_wr(input logic [59:0] got, input logic [59:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD %0t internal write got %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_slv(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD %0t slave side got %h want %h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The prediction is queued before the byte goes out.
  task automatic w(input logic [31:0] r);
    if (p < 4) addr[8*p +: 8] = r[7:0];
    else if (p < 8) data[8*(p-4) +: 8] = r[7:0];
    addr[1:0] = 2'b00;
    if (p == 7 && size == 2'h3) exp_q.push_back({addr[23:0], data, 4'hf});
    if (p == 7 && inc) addr = addr + 32'h4;
    p = (p == 7) ? 4 : p + 1;
    i2c_master_model_inst.op(1'b1, r[7:0]);
  endtask
  task automatic s(input logic [7:0] sp_v);
    i2c_master_model_inst.start(sp_v);
    p = sp_v;
  endtask
  task automatic rr(input logic [23:0] a, input logic [31:0] e);
    logic h;
    h = (a == `WRITE_ADDRESS_FIELD_REG_OFFSET) || (a == `WDATA_REG_OFFSET);
    @(negedge clk);
    rd = 1;
    ra = a;
    @(negedge clk);
    cmp_reg({hit, rdata}, {h, e});
    rd = 0;
  endtask
  task automatic bl(input logic d);
    @(negedge clk);
    bw = $random(seed);
    {bal, bdl} = {!d, d};
    @(negedge clk);
    {bal, bdl} = 2'b00;
    if (d) data = bw;
    else addr = bw & `ADDR_ALIGN_MASK;
  endtask
  always #5 clk = ~clk;
  // Outputs are looked at on the falling edge, half a cycle after launch.
  always @(negedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test;
    end
    if (iw === 1'b1) begin
      want_wr = exp_q.size() ? exp_q.pop_front() : 60'h1;
      cmp_wr({iwa, iwd, iwl}, want_wr);
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    rr(24'h01d208, 0);
    s(8'h00);
    repeat (16) w($random(seed));
    rr(`WRITE_ADDRESS_FIELD_REG_OFFSET, addr);
    rr(`WDATA_REG_OFFSET, data);
    cmp_slv(srd, data[7:0]);
    inc = 0;
    s(8'h04);
    repeat (7) w($random(seed));
    size = 2'h0;
    w($random(seed));
    size = 2'h3;
    s(8'h08);
    w($random(seed));
    rr(`WRITE_ADDRESS_FIELD_REG_OFFSET, addr);
    rr(`WDATA_REG_OFFSET, data);
    s(8'h07);
    cmp_slv(srd, data[31:24]);
    i2c_master_model_inst.op(1'b0, 8'h00);
    cmp_slv(ptr, 8'h08);
    bl(0);
    bl(1);
    bl(0);
    rr(`WRITE_ADDRESS_FIELD_REG_OFFSET, addr);
    rr(`WDATA_REG_OFFSET, data);
    cmp_wr(exp_q.size(), 60'h0);
    stop_test;
  end
endmodule // tb
